/* core/adcctl_top.sv */
// Converter control block: registers, bit clock, successive approximation
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module adcctl_top
  import adcctl_pkg::*;
#(
  parameter int        LARGE_PART   = 1,
  parameter logic [9:0] TEMP_REF_VAL = adcctl_pkg::TEMP_REF_DEFAULT
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         rc_osc_tick_i,
  input  wire logic                         cmp_high_i,
  input  wire logic [31:0]                  wb_adr_i,
  input  wire logic [31:0]                  wb_dat_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic                         wb_we_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  output logic      [adcctl_pkg::CH_W-1:0]  mux_sel_o,
  output logic                              mux_valid_o,
  output logic                              sample_hold_o,
  output logic      [adcctl_pkg::RES_W-1:0] dac_code_o,
  output logic                              irq_o
);
  import adcctl_pkg::*;

  typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONV, ADCC_ABORT} adcc_state_t;

  typedef struct packed {
    adcc_state_t       st;
    logic              on;
    logic              run;
    logic [CH_W-1:0]   ch;
    logic [2:0]        clksel;
    logic [RES_W-1:0]  res;
    logic [RES_W-1:0]  trial;
    logic [3:0]        bitn;
    logic [1:0]        abort_cnt;
    logic [6:0]        div_cnt;
    logic              done_sts;
    logic              done_en;
    logic [31:0]       rdata;
    logic              ack;
    logic              irq;
    logic              mux_valid;
    logic              sh;
    logic              osc_s1;
    logic              osc_s2;
    logic              osc_s3;
    logic              cmp_s1;
    logic              cmp_s2;
  } adcc_state_s_t;

  adcc_state_s_t r;
  adcc_state_s_t next_r;

  // Divide ratio for a select code; zero marks a reserved code
  function automatic logic [6:0] div_ratio(input logic [2:0] sel);
    case (sel)
      CLK_DIV8:  div_ratio = DIV_8;
      CLK_DIV16: div_ratio = DIV_16;
      CLK_DIV32: div_ratio = DIV_32;
      CLK_DIV64: div_ratio = DIV_64;
      default:   div_ratio = (sel[1:0] == 2'b11) ? DIV_RC : 7'h00;
    endcase
  endfunction

  // A channel exists if it is one of the implemented mux inputs
  function automatic logic ch_exists(input logic [4:0] ch);
    if (ch >= 5'h18) begin
      ch_exists = (LARGE_PART != 0) || (ch <= 5'h1C);
    end else begin
      ch_exists = (ch <= 5'h0F) && (ch != 5'h08) && (ch != 5'h09);
    end
  endfunction

  logic       wb_req;
  logic       tick;
  logic       rc_mode;
  logic       is_wr;

  always_comb begin
    wb_req  = wb_cyc_i && wb_stb_i && !r.ack;
    is_wr   = wb_req && wb_we_i && wb_sel_i[0];
    rc_mode = (r.clksel[1:0] == 2'b11);
    next_r  = r;
    next_r.ack = wb_req;
    // Synchronisers for the oscillator tick and comparator
    next_r.osc_s1 = rc_osc_tick_i;
    next_r.osc_s2 = r.osc_s1;
    next_r.osc_s3 = r.osc_s2;
    next_r.cmp_s1 = cmp_high_i;
    next_r.cmp_s2 = r.cmp_s1;

    // Bit clock enable; RC ticks are counted, system clock cycles otherwise
    tick = 1'b0;
    if (!r.on || r.st == ADCC_IDLE || div_ratio(r.clksel) == 7'h00) begin
      next_r.div_cnt = 7'h00;
    end else if (!rc_mode || (r.osc_s2 && !r.osc_s3)) begin
      if (r.div_cnt == div_ratio(r.clksel) - 7'h01) begin
        next_r.div_cnt = 7'h00;
        tick           = 1'b1;
      end else begin
        next_r.div_cnt = r.div_cnt + 7'h01;
      end
    end

    // Register writes
    if (is_wr) begin
      case (wb_adr_i[7:0])
        ADDR_CTRL0: begin
          next_r.on = wb_dat_i[CTRL0_ON_BIT];
          next_r.ch = wb_dat_i[CTRL0_CH_LSB +: CH_W];
          if (wb_dat_i[CTRL0_RUN_BIT] && r.on && r.st == ADCC_IDLE) begin
            next_r.run   = 1'b1;
            next_r.st    = ADCC_CONV;
            next_r.bitn  = 4'h0;
            next_r.trial = {1'b1, {(RES_W-1){1'b0}}};
            next_r.sh    = 1'b0;
          end else if (!wb_dat_i[CTRL0_RUN_BIT] && r.st == ADCC_CONV) begin
            next_r.run       = 1'b0;
            next_r.st        = ADCC_ABORT;
            next_r.abort_cnt = 2'h0;
          end
        end
        ADDR_CTRL1:  next_r.clksel  = wb_dat_i[CTRL1_CLK_LSB +: CLKSEL_W];
        ADDR_IRQ_EN: next_r.done_en = wb_dat_i[IRQ_DONE_BIT];
        ADDR_IRQ_CLR: begin
          if (wb_dat_i[IRQ_DONE_BIT]) begin
            next_r.done_sts = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Conversion sequencer
    case (r.st)
      ADCC_IDLE: begin
        next_r.sh = r.on;
      end
      ADCC_CONV: begin
        if (tick) begin
          // Period 0 holds the sample; periods 1..10 resolve one bit each
          if (r.bitn != 4'h0) begin
            if (!r.cmp_s2) begin
              next_r.trial = r.trial & ~(10'h200 >> (r.bitn - 4'h1));
            end
            if (r.bitn < 4'hA) begin
              next_r.trial = (r.cmp_s2 ? r.trial : r.trial & ~(10'h200 >> (r.bitn - 4'h1)))
                             | (10'h200 >> r.bitn);
            end
          end
          next_r.bitn = r.bitn + 4'h1;
          if (r.bitn == CONV_PERIODS - 4'h1) begin
            next_r.st       = ADCC_IDLE;
            next_r.run      = 1'b0;
            next_r.done_sts = 1'b1;
            next_r.res      = r.cmp_s2 ? r.trial : (r.trial & 10'h3FE);
          end
        end
      end
      ADCC_ABORT: begin
        if (tick) begin
          next_r.abort_cnt = r.abort_cnt + 2'h1;
          if (r.abort_cnt == ABORT_PERIODS - 2'h1) begin
            next_r.st = ADCC_IDLE;
          end
        end
      end
      default: next_r.st = ADCC_IDLE;
    endcase

    // Turning off ends any conversion, without a result unless the last period ends in that cycle
    if (!next_r.on) begin
      next_r.st      = ADCC_IDLE;
      next_r.run     = 1'b0;
      next_r.div_cnt = 7'h00;
    end
    // Sample only while on and idle, so the hold opens by itself after an abort
    next_r.sh = next_r.on && (next_r.st == ADCC_IDLE);

    // Die temperature is always valid; it needs no enable
    next_r.mux_valid = ch_exists(next_r.ch);
    next_r.irq       = next_r.done_sts && next_r.done_en;

    // Read data
    next_r.rdata = 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i[7:0])
        ADDR_CTRL0: next_r.rdata = {25'h000_0000, r.ch, r.run, r.on};
        ADDR_CTRL1: next_r.rdata = {25'h000_0000, r.clksel, 4'h0};
        ADDR_RES_HIGH: next_r.rdata = {30'h0000_0000, r.res[9:8]};
        ADDR_RES_LOW:  next_r.rdata = {24'h00_0000, r.res[7:0]};
        ADDR_TEMP_REF: next_r.rdata = {22'h00_0000, TEMP_REF_VAL};
        ADDR_IRQ_STAT: next_r.rdata = {31'h0000_0000, r.done_sts};
        ADDR_IRQ_EN:   next_r.rdata = {31'h0000_0000, r.done_en};
        default:       next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r        <= '0;
      r.st     <= ADCC_IDLE;
      r.res    <= RES_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o      = r.rdata;
  assign wb_ack_o      = r.ack;
  assign mux_sel_o     = r.ch;
  assign mux_valid_o   = r.mux_valid;
  assign sample_hold_o = r.sh;
  assign dac_code_o    = r.trial;
  assign irq_o         = r.irq;

  // Assertions
  property p_done_on_finish;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_CONV && next_r.st == ADCC_IDLE && r.on && next_r.on)
        |=> (r.done_sts && !r.run);
  endproperty
  a_done_on_finish: assert property (p_done_on_finish) else $error("done not set at end");

  property p_abort_keeps;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_ABORT) |=> $stable(r.res);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("result changed on abort");

  property p_off_idle;
    @(posedge clk_i) disable iff (rst_i)
      !r.on |-> (r.st == ADCC_IDLE && r.div_cnt == 7'h00);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("activity while off");

  property p_done_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (r.done_sts && !(is_wr && wb_adr_i[7:0] == ADDR_IRQ_CLR)) |=> r.done_sts;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (irq_o == (r.done_sts && r.done_en));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

  property p_mux_follows;
    @(posedge clk_i) disable iff (rst_i)
      (is_wr && wb_adr_i[7:0] == ADDR_CTRL0) |=> (mux_sel_o == $past(wb_dat_i[6:2]));
  endproperty
  a_mux_follows: assert property (p_mux_follows) else $error("channel not taken");

  property p_div8_tick;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_CONV && r.clksel == CLK_DIV8 && r.div_cnt == 7'h07 && r.on) |-> tick;
  endproperty
  a_div8_tick: assert property (p_div8_tick) else $error("bit clock period wrong");

  property p_res_range;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_CONV) |-> (r.bitn < CONV_PERIODS);
  endproperty
  a_res_range: assert property (p_res_range) else $error("bit count overran");

  property p_temp_ch;
    @(posedge clk_i) disable iff (rst_i)
      (r.ch == CH_DIE_TEMP) |-> mux_valid_o;
  endproperty
  a_temp_ch: assert property (p_temp_ch) else $error("die temp channel invalid");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_abort_two;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_ABORT && tick && r.abort_cnt == ABORT_PERIODS - 2'h1)
        |=> (r.st == ADCC_IDLE);
  endproperty
  a_abort_two: assert property (p_abort_two) else $error("abort wait too long");

  property p_abort_wait;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_ABORT && !tick && next_r.on) |=> (r.st == ADCC_ABORT);
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort ended early");

  property p_acquire;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_ABORT && next_r.st == ADCC_IDLE && next_r.on) |=> sample_hold_o;
  endproperty
  a_acquire: assert property (p_acquire) else $error("no acquisition after abort");

  property p_trial_start;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_IDLE && next_r.st == ADCC_CONV) |=> (dac_code_o == 10'h200);
  endproperty
  a_trial_start: assert property (p_trial_start) else $error("first trial wrong");

  property p_no_start_off;
    @(posedge clk_i) disable iff (rst_i)
      (is_wr && wb_adr_i[7:0] == ADDR_CTRL0 && !r.on) |=> (r.st == ADCC_IDLE);
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("start while off");

  property p_tick_idle;
    @(posedge clk_i) disable iff (rst_i)
      (r.st == ADCC_IDLE) |-> !tick;
  endproperty
  a_tick_idle: assert property (p_tick_idle) else $error("bit clock while idle");

  property p_rc_edge;
    @(posedge clk_i) disable iff (rst_i)
      (rc_mode && tick) |-> (r.osc_s2 && !r.osc_s3);
  endproperty
  a_rc_edge: assert property (p_rc_edge) else $error("rc tick without edge");

  property p_busy_on;
    @(posedge clk_i) disable iff (rst_i)
      (r.st != ADCC_IDLE) |-> r.on;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy while off");
endmodule

/* shared/adcctl_pkg.sv */
// Package of constants for the converter control block
package adcctl_pkg;
  // Register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_CTRL0    = 8'h00;
  localparam logic [7:0] ADDR_CTRL1    = 8'h04;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h0C;
  localparam logic [7:0] ADDR_TEMP_REF = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h1C;
  // Control 0 fields
  localparam int CTRL0_ON_BIT  = 0;
  localparam int CTRL0_RUN_BIT = 1;
  localparam int CTRL0_CH_LSB  = 2;
  localparam int CH_W          = 5;
  // Control 1 fields
  localparam int CTRL1_CLK_LSB = 4;
  localparam int CLKSEL_W      = 3;
  // Clock select codes
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  // Divide ratios
  localparam logic [6:0] DIV_8   = 7'h08;
  localparam logic [6:0] DIV_16  = 7'h10;
  localparam logic [6:0] DIV_32  = 7'h20;
  localparam logic [6:0] DIV_64  = 7'h40;
  localparam logic [6:0] DIV_RC  = 7'h10;
  // Conversion timing
  localparam int RES_W          = 10;
  localparam logic [3:0] CONV_PERIODS  = 4'hB;
  localparam logic [1:0] ABORT_PERIODS = 2'h2;
  // Channels
  localparam logic [4:0] CH_DIE_TEMP = 5'h0D;
  localparam int CH_COUNT_LARGE = 24;
  localparam int CH_COUNT_SMALL = 21;
  // Reset values
  localparam logic [9:0] TEMP_REF_DEFAULT = 10'h000;
  localparam logic [9:0] RES_RESET        = 10'h000;
  // Interrupt status bit
  localparam int IRQ_DONE_BIT = 0;
endpackage

/* verification/adcctl_analog_model.sv */
// Analog side model: per-channel levels, comparator and RC oscillator
`timescale 1ns/1ps
module adcctl_analog_model #(
  parameter int RC_HALF = 3
) (
  input  wire logic       clk_i,
  input  wire logic [4:0] mux_sel_i,
  input  wire logic [9:0] dac_code_i,
  output logic            cmp_high_o,
  output logic            rc_osc_tick_o
);
  int   cnt   = 0;
  logic osc_q = 1'b0;
  // Each channel, the die temperature one included, has its own level
  // External pins are taken as already set to input and analog
  assign cmp_high_o = {mux_sel_i, ~mux_sel_i} >= dac_code_i;
  assign rc_osc_tick_o = osc_q;
  // Free-running: the oscillator never stops, unlike a link clock
  always @(posedge clk_i) begin
    cnt <= (cnt == RC_HALF - 1) ? 0 : cnt + 1;
    if (cnt == RC_HALF - 1) begin
      osc_q <= ~osc_q;
    end
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  import adcctl_pkg::*;
  localparam logic [9:0] TREF = 10'h2C5;
  logic        clk_i, rst_i, rc_tick, cmp_high, wb_we_i, wb_cyc_i, wb_stb_i;
  logic        wb_ack_o, mux_valid_o, sample_hold_o, irq_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
  logic [3:0]  wb_sel_i;
  logic [4:0]  mux_sel_o;
  logic [9:0]  dac_code;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  adcctl_top #(.LARGE_PART(1), .TEMP_REF_VAL(TREF)) adcctl_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .rc_osc_tick_i(rc_tick), .cmp_high_i(cmp_high),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mux_sel_o(mux_sel_o), .mux_valid_o(mux_valid_o), .sample_hold_o(sample_hold_o),
    .dac_code_o(dac_code), .irq_o(irq_o));
  adcctl_analog_model #(.RC_HALF(3)) adcctl_analog_model_i (
    .clk_i(clk_i), .mux_sel_i(mux_sel_o), .dac_code_i(dac_code),
    .cmp_high_o(cmp_high), .rc_osc_tick_o(rc_tick));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [9:0] lvl(input logic [4:0] c);
    return {c, ~c};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under 6000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= {24'h00_0000, a};
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(a, 1'b0, 32'h0000_0000);
    chk(nm, e, q);
  endtask

  task automatic start(input logic [4:0] ch, input logic [2:0] cs);
    wb(ADDR_CTRL1, 1'b1, {25'h000_0000, cs, 4'h0});
    wb(ADDR_CTRL0, 1'b1, {25'h000_0000, ch, 2'b01});
    repeat (20) @(posedge clk_i); // Acquisition wait
    wb(ADDR_CTRL0, 1'b1, {25'h000_0000, ch, 2'b11});
  endtask

  task automatic clear_irq();
    wb(ADDR_IRQ_CLR, 1'b1, 32'h0000_0001);
    @(posedge clk_i);
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "status");
    chk("irq_o", 32'h0, 32'(irq_o));
  endtask

  task automatic s_reset();
    rd(ADDR_CTRL0, 32'h0000_0000, "ctrl0");
    rd(ADDR_RES_HIGH, 32'h0000_0000, "res_high");
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "status");
    rd(ADDR_TEMP_REF, 32'(TREF), "temp_ref");
    wb(8'h20, 1'b1, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, "unmapped");
  endtask

  task automatic s_valid();
    logic [4:0] channel_select_field[3] = '{5'd20, 5'd27, 5'd13};
    logic       ok[3] = '{1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 3; i++) begin
      wb(ADDR_CTRL0, 1'b1, {25'h000_0000, channel_select_field[i], 2'b01});
      @(posedge clk_i);
      chk("mux_sel", 32'(channel_select_field[i]), 32'(mux_sel_o));
      chk("mux_valid", 32'(ok[i]), 32'(mux_valid_o));
    end
  endtask

  // Every non-reserved clock code, timed by the done interrupt; /8 is legal at this rate
  // The RC code runs awake here only to time its path
  task automatic s_clocks();
    logic [2:0] cs[6] = '{CLK_DIV8, CLK_DIV16, CLK_DIV32, CLK_DIV64, 3'h3, 3'h7};
    int         per[6] = '{8, 16, 32, 64, 96, 96};
    logic [4:0] channel_select_field[6] = '{5'd13, 5'd24, 5'd0, 5'd31, 5'd5, 5'd26};
    int         n;
    wb(ADDR_IRQ_EN, 1'b1, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      n = 0;
      start(channel_select_field[i], cs[i]);
      while (irq_o !== 1'b1 && n < 2000) begin
        @(posedge clk_i);
        n++;
      end
      chk("conv_time", 32'h1, 32'(n > 10 * per[i] && n <= 12 * per[i]));
      rd(ADDR_CTRL0, {25'h000_0000, channel_select_field[i], 2'b01}, "ctrl0");
      rd(ADDR_RES_HIGH, 32'(lvl(channel_select_field[i]) >> 8), "res_high");
      rd(ADDR_RES_LOW, 32'(lvl(channel_select_field[i]) & 10'h0FF), "res_low");
      clear_irq();
    end
  endtask

  task automatic s_mask();
    wb(ADDR_IRQ_EN, 1'b1, 32'h0000_0000);
    start(CH_DIE_TEMP, CLK_DIV8);
    repeat (120) @(posedge clk_i);
    rd(ADDR_IRQ_STAT, 32'h0000_0001, "status");
    chk("irq_masked", 32'h0, 32'(irq_o));
    wb(ADDR_IRQ_EN, 1'b1, 32'h0000_0001);
    @(posedge clk_i);
    chk("irq_enabled", 32'h1, 32'(irq_o));
    clear_irq();
  endtask

  // Abort mid-run: old result kept, acquisition resumes after two periods
  task automatic s_abort();
    start(5'd24, CLK_DIV64);
    repeat (200) @(posedge clk_i);
    chk("hold_busy", 32'h0, 32'(sample_hold_o));
    wb(ADDR_CTRL0, 1'b1, {25'h000_0000, 5'd24, 2'b01});
    repeat (140) @(posedge clk_i);
    chk("acquire", 32'h1, 32'(sample_hold_o));
    repeat (600) @(posedge clk_i);
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "status");
    rd(ADDR_RES_LOW, 32'(lvl(CH_DIE_TEMP) & 10'h0FF), "res_low");
  endtask

  task automatic s_off();
    wb(ADDR_CTRL0, 1'b1, {25'h000_0000, CH_DIE_TEMP, 2'b10});
    repeat (150) @(posedge clk_i);
    rd(ADDR_CTRL0, {25'h000_0000, CH_DIE_TEMP, 2'b00}, "ctrl0");
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "status");
    chk("sample_hold", 32'h0, 32'(sample_hold_o));
  endtask

  // Reserved clock code: the run stays pending until the converter is turned off
  task automatic s_reserved();
    start(CH_DIE_TEMP, 3'h0);
    repeat (100) @(posedge clk_i);
    rd(ADDR_CTRL0, {25'h000_0000, CH_DIE_TEMP, 2'b11}, "ctrl0");
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "status");
    wb(ADDR_CTRL0, 1'b1, {25'h000_0000, CH_DIE_TEMP, 2'b00});
    rd(ADDR_CTRL0, {25'h000_0000, CH_DIE_TEMP, 2'b00}, "ctrl0");
    rd(ADDR_RES_LOW, 32'(lvl(CH_DIE_TEMP) & 10'h0FF), "res_low");
  endtask

  initial begin
    rst_i = 1'b1;
    wb_adr_i = 32'h0000_0000;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_valid();
    s_clocks();
    s_mask();
    s_abort();
    s_off();
    s_reserved();
    test_done();
  end
endmodule
